// file: iot_pkg.sv
package iot_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register map
    localparam logic [11:0] ADDR_TRIM = 12'h000;
    localparam logic [11:0] ADDR_STATUS = 12'h004;
    localparam logic [7:0] TRIM_RESET = 8'h00;

    ////////////////////////////////////////////////////////////////////////////
    // Trim register fields
    localparam int SRC_BIT = 7;
    localparam int PLL_BIT = 6;
    localparam int RSVD_BIT = 5;
    localparam int TUNE_MSB = 4;
    localparam int TUNE_LSB = 0;
    localparam int TUNE_W = TUNE_MSB - TUNE_LSB + 1;

    ////////////////////////////////////////////////////////////////////////////
    // Status register fields
    localparam int ST_PLL_ON = 0;
    localparam int ST_SRC_DIV = 1;
    localparam int ST_PLL_AVAIL = 2;
    localparam int ST_FREQ_OK = 3;

    ////////////////////////////////////////////////////////////////////////////
    // Low-frequency divider
    localparam int FAST_OSC_KHZ = 8000;
    localparam int LF_DIV_HZ = 31250;
    localparam int DIV_RATIO = FAST_OSC_KHZ * 1000 / LF_DIV_HZ;
    localparam int DIV_W = $clog2(DIV_RATIO);
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(DIV_RATIO - 1);

    ////////////////////////////////////////////////////////////////////////////
    // Fast oscillator frequency codes that allow the PLL
    localparam logic [2:0] FREQ_4MHZ = 3'h6;
    localparam logic [2:0] FREQ_8MHZ = 3'h7;

    function automatic logic pllFreqOk(input logic [2:0] freqSel);
        return (freqSel == FREQ_4MHZ) || (freqSel == FREQ_8MHZ);
    endfunction

endpackage

// file: iot_reg_if.sv
`timescale 1ns/100ps
interface iot_reg_if;
    logic wrStb;
    logic rdStb;
    logic [11:0] addr;
    logic [7:0] wdata;
    logic [31:0] rdata;
    logic hit;

    modport slave (
        output wrStb,
        output rdStb,
        output addr,
        output wdata,
        input rdata,
        input hit
    );

    modport core (
        input wrStb,
        input rdStb,
        input addr,
        input wdata,
        output rdata,
        output hit
    );
endinterface

// file: iot_apb_slave.sv
`timescale 1ns/100ps
module iot_apb_slave (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    iot_reg_if.slave regs
);
    import iot_pkg::*;

    logic [31:0] prdata_r;
    wire setupRead = psel && !penable && !pwrite;
    wire access = psel && penable;

    assign regs.addr = paddr;
    assign regs.wdata = pwdata[7:0];
    assign regs.wrStb = access && pwrite && regs.hit;
    assign regs.rdStb = setupRead;

    // No wait states: read data is caught in the setup cycle
    assign pready = 1'b1;
    assign pslverr = access && !regs.hit;
    assign prdata = prdata_r;

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            prdata_r <= 32'h00000000;
        end else if (regs.rdStb) begin
            prdata_r <= regs.hit ? regs.rdata : 32'h00000000;
        end
    end
endmodule

// file: iot_lf_div.sv
`timescale 1ns/100ps
module iot_lf_div (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic fastOscTick,
    output logic divTick
);
    import iot_pkg::*;

    logic [DIV_W-1:0] divCnt_r;

    // Free running so the output phase does not jump on source changes
    assign divTick = fastOscTick && (divCnt_r == DIV_LAST);

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            divCnt_r <= '0;
        end else if (fastOscTick) begin
            divCnt_r <= divCnt_r + DIV_W'(1);
        end
    end
endmodule

// file: iot_top.sv
// Implementation choices: the address map and the APB slave port.
`timescale 1ns/100ps
module iot_top (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic fastOscTick,
    input wire logic slowRcIn,
    input wire logic pllSupported,
    input wire logic [2:0] fastOscFreqSel,
    output logic lowFreqTick,
    output logic lowFreqSrcDiv,
    output logic pllEngage,
    output logic [iot_pkg::TUNE_W-1:0] freqTrim
);
    import iot_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Declarations

    iot_reg_if regs ();

    logic srcSel_r;
    logic pll_multiplier_enable_r;
    logic [TUNE_W-1:0] tune_r;
    logic srcSel_nxt;
    logic pll_multiplier_enable_nxt;
    logic [TUNE_W-1:0] tune_nxt;

    logic rcPrev_r;
    logic lowFreqTick_r;
    logic lowFreqTick_nxt;
    logic pllEngage_r;
    logic pllEngage_nxt;

    logic divTick;
    wire rcRise = slowRcIn && !rcPrev_r;

    ////////////////////////////////////////////////////////////////////////////
    // Bus slave and divider

    iot_apb_slave u_apb (
        .mclk(mclk),
        .rstn(rstn),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .regs(regs)
    );

    iot_lf_div u_div (
        .mclk(mclk),
        .rstn(rstn),
        .fastOscTick(fastOscTick),
        .divTick(divTick)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Address decode

    wire selTrim = (regs.addr == ADDR_TRIM);
    wire selStatus = (regs.addr == ADDR_STATUS);
    wire wrTrim = regs.wrStb && selTrim;

    assign regs.hit = selTrim || selStatus;

    ////////////////////////////////////////////////////////////////////////////
    // Read data

    // Bit six masked on read as well, since support may be withdrawn
    wire pllVisible = pll_multiplier_enable_r && pllSupported;

    wire [7:0] trimRead = {srcSel_r, pllVisible, 1'b0, tune_r};

    wire [7:0] statusRead = {
        4'h0,
        pllFreqOk(fastOscFreqSel),
        pllSupported,
        srcSel_r,
        pllEngage_r
    };

    assign regs.rdata = selTrim ? {24'h000000, trimRead}
        : selStatus ? {24'h000000, statusRead}
        : 32'h00000000;

    ////////////////////////////////////////////////////////////////////////////
    // Trim register

    // Enable only stored when the configuration offers a PLL
    assign pll_multiplier_enable_nxt = wrTrim ? (regs.wdata[PLL_BIT] && pllSupported)
        : (pll_multiplier_enable_r && pllSupported);
    assign srcSel_nxt = wrTrim ? regs.wdata[SRC_BIT] : srcSel_r;
    assign tune_nxt = wrTrim ? regs.wdata[TUNE_MSB:TUNE_LSB] : tune_r;

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            srcSel_r <= TRIM_RESET[SRC_BIT];
            pll_multiplier_enable_r <= TRIM_RESET[PLL_BIT];
            tune_r <= TRIM_RESET[TUNE_MSB:TUNE_LSB];
        end else begin
            srcSel_r <= srcSel_nxt;
            pll_multiplier_enable_r <= pll_multiplier_enable_nxt;
            tune_r <= tune_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Low-frequency clock selection

    // Both sources stay live, so switching loses at most one period
    assign lowFreqTick_nxt = srcSel_r ? divTick : rcRise;

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            rcPrev_r <= 1'b0;
            lowFreqTick_r <= 1'b0;
        end else begin
            rcPrev_r <= slowRcIn;
            lowFreqTick_r <= lowFreqTick_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // PLL engage

    // Any other frequency keeps the PLL off even with the bit set
    assign pllEngage_nxt = pllVisible && pllFreqOk(fastOscFreqSel);

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            pllEngage_r <= 1'b0;
        end else begin
            pllEngage_r <= pllEngage_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign lowFreqTick = lowFreqTick_r;
    assign lowFreqSrcDiv = srcSel_r;
    assign pllEngage = pllEngage_r;
    // Trim code to the oscillator: higher code, higher frequency
    assign freqTrim = tune_r;

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge mclk);
    endclocking

    default disable iff (!rstn);

    // Independent reference for the divider phase
    logic [DIV_W-1:0] refCnt_r;

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            refCnt_r <= '0;
        end else if (fastOscTick) begin
            refCnt_r <= refCnt_r + DIV_W'(1);
        end
    end

    wire refWrap = fastOscTick && (refCnt_r == DIV_LAST);

    sequence trimReadSetup;
        psel && !penable && !pwrite && (paddr == ADDR_TRIM);
    endsequence

    sequence trimWriteAccess;
        psel && penable && pwrite && (paddr == ADDR_TRIM);
    endsequence

    sequence statusReadSetup;
        psel && !penable && !pwrite && (paddr == ADDR_STATUS);
    endsequence

    sequence statusWriteAccess;
        psel && penable && pwrite && (paddr == ADDR_STATUS);
    endsequence

    // Anything outside the two words is refused
    wire unmappedAddr = (paddr != ADDR_TRIM) && (paddr != ADDR_STATUS);

    sequence fastWrapInDivMode;
        srcSel_r && refWrap;
    endsequence

    AST_DIV_TICK: assert property (
        fastWrapInDivMode |=> lowFreqTick
    ) else $error("divided low clock tick missing");

    AST_DIV_ONLY: assert property (
        (srcSel_r && !refWrap) |=> !lowFreqTick
    ) else $error("divided low clock tick at wrong count");

    AST_RC_TICK: assert property (
        (!srcSel_r && slowRcIn && !$past(slowRcIn)) |=> lowFreqTick
    ) else $error("slow RC edge not passed to low clock");

    AST_RC_ONLY: assert property (
        (!srcSel_r && !(slowRcIn && !$past(slowRcIn))) |=> !lowFreqTick
    ) else $error("low clock tick without slow RC edge");

    AST_PLL_ON: assert property (
        (pll_multiplier_enable_r && pllSupported && pllFreqOk(fastOscFreqSel)) |=> pllEngage
    ) else $error("PLL not engaged at supported frequency");

    AST_PLL_OFF: assert property (
        (!pllFreqOk(fastOscFreqSel) || !pll_multiplier_enable_r) |=> !pllEngage
    ) else $error("PLL engaged while disabled or off-frequency");

    AST_PLL_RD0: assert property (
        (trimReadSetup and !pllSupported) |=> (prdata[PLL_BIT] == 1'b0)
    ) else $error("PLL enable bit read as one without support");

    AST_TRIM_WR: assert property (
        trimWriteAccess |=> (freqTrim == $past(pwdata[TUNE_MSB:TUNE_LSB]))
    ) else $error("trim field did not take written value");

    AST_TRIM_HOLD: assert property (
        !(psel && penable && pwrite) |=> $stable(freqTrim)
    ) else $error("trim field changed without a write");

    AST_RSVD: assert property (
        trimReadSetup |=> (prdata[31:RSVD_BIT] == 27'h0000000 || prdata[RSVD_BIT] == 1'b0)
            && (prdata[31:8] == 24'h000000)
    ) else $error("reserved bits of trim register read nonzero");

    AST_SRC_RD: assert property (
        (trimWriteAccess ##2 trimReadSetup)
            |=> (prdata[SRC_BIT] == $past(pwdata[SRC_BIT], 3))
    ) else $error("source select read back differs from write");

    AST_SRC_WR: assert property (
        trimWriteAccess |=> (lowFreqSrcDiv == $past(pwdata[SRC_BIT]))
    ) else $error("source select did not take written value");

    AST_SRC_HOLD: assert property (
        !(psel && penable && pwrite) |=> $stable(lowFreqSrcDiv)
    ) else $error("source select changed without a write");

    AST_DIV_PULSE: assert property (
        (srcSel_r && $past(srcSel_r) && lowFreqTick) |=> !lowFreqTick
    ) else $error("divided low clock tick longer than one cycle");

    AST_RC_PULSE: assert property (
        (!srcSel_r && !$past(srcSel_r) && lowFreqTick) |=> !lowFreqTick
    ) else $error("slow RC low clock tick longer than one cycle");

    AST_PLL_RD1: assert property (
        (trimReadSetup and (pll_multiplier_enable_r && pllSupported)) |=> prdata[PLL_BIT]
    ) else $error("enabled PLL bit read back as zero");

    AST_PLL_UNSUP: assert property (
        !pllSupported |=> !pllEngage
    ) else $error("PLL engaged without oscillator support");

    AST_STATUS_RO: assert property (
        statusWriteAccess |=> $stable(freqTrim)
    ) else $error("status write changed the trim field");

    AST_TRIM_RD: assert property (
        trimReadSetup |=> (prdata[TUNE_MSB:TUNE_LSB] == $past(freqTrim))
    ) else $error("trim field read back differs from its value");

    AST_STATUS_RD: assert property (
        statusReadSetup |=> (prdata[ST_PLL_ON] == $past(pllEngage))
            && (prdata[ST_PLL_AVAIL] == $past(pllSupported))
            && (prdata[ST_FREQ_OK] == $past((fastOscFreqSel == FREQ_4MHZ)
            || (fastOscFreqSel == FREQ_8MHZ)))
    ) else $error("status read differs from PLL state");

    AST_UNMAP_RD0: assert property (
        (psel && !penable && !pwrite && unmappedAddr) |=> (prdata == 32'h00000000)
    ) else $error("unmapped read returned nonzero data");

    AST_UNMAP_ERR: assert property (
        (psel && penable && unmappedAddr) |-> pslverr
    ) else $error("unmapped access not refused");

endmodule

// file: testbench.sv
`timescale 1ns/100ps
module testbench;
    import iot_pkg::*;

    typedef struct packed {
        logic [7:0] wr;
        logic sup;
        logic [2:0] freq;
        logic [7:0] rd;
        logic pll;
    } iot_row_t;

    logic mclk = 1'b0;
    logic rstn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic fastOscTick = 1'b0;
    logic slowRcIn = 1'b0;
    logic pllSupported = 1'b0;
    logic [2:0] fastOscFreqSel = 3'h0;
    logic lowFreqTick;
    logic lowFreqSrcDiv;
    logic pllEngage;
    logic [TUNE_W-1:0] freqTrim;
    int err_total = 0;
    int total_checks = 0;
    int pulseCnt = 0;
    logic [31:0] rdVal;
    logic rdErr;
    logic freqOk;
    int gap;

    // Inputs sweep PLL support and frequency code before each write
    iot_row_t rows [8] = '{
        '{8'hff, 1'b1, 3'h7, 8'hdf, 1'b1},
        '{8'h7f, 1'b1, 3'h6, 8'h5f, 1'b1},
        '{8'h40, 1'b1, 3'h5, 8'h40, 1'b0},
        '{8'h40, 1'b0, 3'h7, 8'h00, 1'b0},
        '{8'h9f, 1'b1, 3'h7, 8'h9f, 1'b0},
        '{8'h20, 1'b1, 3'h7, 8'h00, 1'b0},
        '{8'h01, 1'b1, 3'h0, 8'h01, 1'b0},
        '{8'h1e, 1'b1, 3'h6, 8'h1e, 1'b0}
    };

    iot_top i_iot_top (
        .mclk(mclk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .fastOscTick(fastOscTick), .slowRcIn(slowRcIn),
        .pllSupported(pllSupported), .fastOscFreqSel(fastOscFreqSel),
        .lowFreqTick(lowFreqTick), .lowFreqSrcDiv(lowFreqSrcDiv),
        .pllEngage(pllEngage), .freqTrim(freqTrim)
    );

    always #25 mclk = ~mclk;

    // Counted on the falling edge, where the registered tick has settled
    always @(negedge mclk) begin
        if (lowFreqTick === 1'b1) begin
            pulseCnt++;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Ends one idle edge after release so back-to-back calls never collide
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        // Only the watchdog ends a wait that never sees pready
        while (pready !== 1'b1) begin
            @(posedge mclk);
        end
        rdVal = prdata;
        rdErr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask

    task automatic conclude();
        $display("checks=%0d mismatches=%0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Gap between two low clock pulses, bounded against a stuck divider
    task automatic measureGap(output int g);
        int n;
        n = 0;
        g = 0;
        @(negedge mclk);
        while (lowFreqTick !== 1'b1 && n < 600) begin
            @(negedge mclk);
            n++;
        end
        @(negedge mclk);
        g = 1;
        while (lowFreqTick !== 1'b1 && g < 600) begin
            @(negedge mclk);
            g++;
        end
    endtask

    initial begin
        #(20000 * 50);
        err_total++;
        conclude();
    end

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (3) @(posedge mclk);
        rstn <= 1'b1;
        @(posedge mclk);
        apb(1'b0, ADDR_TRIM, 32'h0);
        check(rdVal, 32'h0);
        check({lowFreqSrcDiv, pllEngage, freqTrim}, 7'h00);
        $display("test reset values done");

        foreach (rows[i]) begin
            pllSupported <= rows[i].sup;
            fastOscFreqSel <= rows[i].freq;
            @(posedge mclk);
            apb(1'b1, ADDR_TRIM, {24'hffffff, rows[i].wr});
            repeat (2) @(posedge mclk);
            apb(1'b0, ADDR_TRIM, 32'h0);
            check(rdVal, {24'h0, rows[i].rd});
            check(pllEngage, rows[i].pll);
            check(lowFreqSrcDiv, rows[i].rd[SRC_BIT]);
            check(freqTrim, rows[i].rd[4:0]);
            freqOk = (rows[i].freq == FREQ_4MHZ) || (rows[i].freq == FREQ_8MHZ);
            apb(1'b0, ADDR_STATUS, 32'h0);
            check(rdVal, {28'h0, freqOk, rows[i].sup, rows[i].rd[7], rows[i].pll});
        end
        $display("test register table done");

        // Unmapped access and status write must leave the trim alone
        apb(1'b1, 12'h008, 32'h0000_0003);
        check(rdErr, 1'b1);
        apb(1'b0, 12'h008, 32'h0);
        check({rdErr, rdVal}, {1'b1, 32'h0});
        apb(1'b1, ADDR_STATUS, 32'h0000_00ff);
        apb(1'b0, ADDR_TRIM, 32'h0);
        check(rdVal, 32'h0000_001e);
        $display("test refused accesses done");

        // Software trim steps: framing error lowers, data error raises
        apb(1'b1, ADDR_TRIM, {24'h0, rdVal[7:0] - 8'h01});
        check(freqTrim, 5'h1d);
        apb(1'b1, ADDR_TRIM, 32'h0000_001f);
        check(freqTrim, 5'h1f);
        $display("test trim steps done");

        // Divided source: one pulse per 256 fast ticks
        apb(1'b1, ADDR_TRIM, 32'h0000_0080);
        apb(1'b0, ADDR_TRIM, 32'h0);
        check(rdVal, 32'h0000_0080);
        fastOscTick <= 1'b1;
        measureGap(gap);
        check(gap, 32'd256);
        pulseCnt = 0;
        repeat (1024) @(posedge mclk);
        check(pulseCnt, 32'd4);
        $display("test divided source done");

        // RC source: one pulse per slow rising edge, fast ticks ignored
        apb(1'b1, ADDR_TRIM, 32'h0000_0000);
        repeat (4) @(posedge mclk);
        pulseCnt = 0;
        repeat (10) begin
            slowRcIn <= 1'b1;
            repeat (10) @(posedge mclk);
            slowRcIn <= 1'b0;
            repeat (10) @(posedge mclk);
        end
        check(pulseCnt, 32'd10);
        fastOscTick <= 1'b0;
        $display("test rc source done");

        // Reset in mid-run clears every implemented bit
        pllSupported <= 1'b1;
        fastOscFreqSel <= 3'h7;
        apb(1'b1, ADDR_TRIM, 32'h0000_00df);
        // Engage lags the stored enable by one edge
        @(posedge mclk);
        check(pllEngage, 1'b1);
        rstn <= 1'b0;
        repeat (3) @(posedge mclk);
        check({lowFreqSrcDiv, pllEngage, freqTrim}, 7'h00);
        rstn <= 1'b1;
        @(posedge mclk);
        apb(1'b0, ADDR_TRIM, 32'h0);
        check(rdVal, 32'h0);
        $display("test mid-run reset done");
        conclude();
    end
endmodule
